// [logic/sfp_defs.svh]
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
// Command opcodes
`define SFP_OP_WRITE_UNLOCK 8'h06
`define SFP_OP_WRITE_LOCK 8'h04
`define SFP_OP_STATUS_READ 8'h05
`define SFP_OP_STATUS_WRITE 8'h01
`define SFP_OP_READ 8'h03
`define SFP_OP_PAGE_WRITE 8'h02
`define SFP_OP_SECTOR_WIPE 8'h20
`define SFP_OP_HALF_BLOCK_WIPE 8'h52
`define SFP_OP_BLOCK_WIPE 8'hd8
`define SFP_OP_CHIP_WIPE_A 8'h60
`define SFP_OP_CHIP_WIPE_B 8'hc7
`define SFP_OP_SECURE_ENTER 8'hb1
`define SFP_OP_SECURE_EXIT 8'hc1
`define SFP_OP_SEC_READ 8'h2b
`define SFP_OP_SEC_WRITE 8'h2f
`define SFP_OP_NOP 8'h00
// Frame byte counts, opcode included
`define SFP_ADDR_BYTES 4'h4
`define SFP_PROG_MIN_BYTES 4'h5
`define SFP_STATUS_WRITE_CMD_SR_BYTES 4'h2
`define SFP_STATUS_WRITE_CMD_CR_BYTES 4'h3
// Status and config bit positions
`define SFP_SR_WIP 0
`define SFP_SR_WEL 1
`define SFP_SR_BP_LO 2
`define SFP_SR_BP_HI 5
`define SFP_SR_QE 6
`define SFP_SR_SRWD 7
`define SFP_CR_TB 3
`define SFP_SEC_FACTORY 0
`define SFP_SEC_CUSTOMER 1
// Address map
`define SFP_BLK_HI 22
`define SFP_BLK_LO 16
`define SFP_OTP_HALF_BIT 9
`define SFP_IDLE_BYTE 8'hff
// Host register offsets
`define SFP_REG_CTRL 8'h00
`define SFP_REG_ADDR 8'h04
`define SFP_REG_WDATA 8'h08
`define SFP_REG_RDATA 8'h0c
`define SFP_REG_STAT 8'h10
`endif

// [logic/sfp_pkg.sv]
package sfp_pkg;
  // Device frame phase
  typedef enum logic [2:0] {DEV_IDLE, DEV_CMD, DEV_ADDR, DEV_DIN, DEV_DOUT, DEV_STANDBY}
    sfp_dev_state_type;
  // Host link sequencer
  typedef enum logic [2:0] {HOST_IDLE, HOST_SETUP, HOST_LO, HOST_HI, HOST_END} sfp_host_state_type;
  // Array operation kinds
  typedef enum logic [2:0] {OP_PROG, OP_SECTOR, OP_HALF_BLOCK, OP_BLOCK, OP_CHIP} sfp_op_type;
endpackage : sfp_pkg

// [logic/sfp_if.sv]
interface sfp_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic wp_n;
  logic so_o;
  logic so_oe;
  logic so;
  // Released output reads high, as with a pull-up
  assign so = so_oe ? so_o : 1'b1;
  modport dev (input cs_n, input sclk, input si, input wp_n, output so_o, output so_oe);
  modport host (output cs_n, output sclk, output si, output wp_n, input so);
endinterface : sfp_if

// [logic/sfp_prot_dec.sv]
module sfp_prot_dec (
  // Protection setting
  input wire logic [3:0] level_in,
  input wire logic protect_from_bottom_in,
  // Block under test
  input wire logic [6:0] block_in,
  output logic protected_out
);
  logic [7:0] span;
  // Number of guarded blocks for codes 1 to 7
  assign span = (level_in[2:0] == 3'h0) ? 8'h00 : (8'h01 << (level_in[2:0] - 3'h1));
  always_comb begin
    if (level_in[3]) begin
      protected_out = 1'b1;
    end else if (protect_from_bottom_in) begin
      protected_out = {1'b0, block_in} < span;
    end else begin
      protected_out = {1'b0, block_in} >= (8'h80 - span);
    end
  end
endmodule : sfp_prot_dec

// [logic/sfp_dev.sv]
`include "sfp_defs.svh"
module sfp_dev (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial link
  sfp_if.dev link,
  // Array side
  input wire logic factory_lock_in,
  input wire logic array_busy_in,
  input wire logic [7:0] rd_data_in,
  output logic [22:0] rd_addr_out,
  output logic rd_otp_out,
  output logic op_start_out,
  output sfp_pkg::sfp_op_type op_kind_out,
  output logic [22:0] op_addr_out,
  output logic [8:0] op_len_out,
  output logic op_otp_out,
  input wire logic [7:0] buf_idx_in,
  output logic [7:0] buf_data_out,
  // Visible state
  output logic secure_mode_out,
  output logic [7:0] status_out
);
  sfp_pkg::sfp_dev_state_type state_r;
  logic cs_q_r, sclk_q_r;
  logic [2:0] bit_cnt_r;
  logic [3:0] byte_cnt_r;
  logic [7:0] op_r, sh_r, tx_r, sr_new_r, cr_new_r;
  logic [23:0] addr_r;
  logic [8:0] plen_r;
  logic [7:0] pbuf [256];
  logic load_pend_r, so_r, so_oe_r;
  logic wel_r, srwd_r, qe_r, tb_r, cust_lock_r, secure_r;
  logic [3:0] bp_r;
  logic cs_fall, cs_rise, sck_rise, sck_fall, byte_done, blk_prot, pin_locked, boundary;
  logic [7:0] byte_in, next_byte, sec_byte;

  // Edge detection of synchronous pins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
    end else begin
      cs_q_r <= link.cs_n;
      sclk_q_r <= link.sclk;
    end
  end
  assign cs_fall = cs_q_r & ~link.cs_n;
  assign cs_rise = ~cs_q_r & link.cs_n;
  // Only edges seen while selected count, so either idle level works
  assign sck_rise = ~sclk_q_r & link.sclk & ~link.cs_n;
  assign sck_fall = sclk_q_r & ~link.sclk & ~link.cs_n;
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
  assign byte_in = {sh_r[6:0], link.si};
  assign boundary = (bit_cnt_r == 3'h0);

  // Command classification
  function automatic logic is_known(input logic [7:0] op);
    case (op)
      `SFP_OP_WRITE_UNLOCK, `SFP_OP_WRITE_LOCK, `SFP_OP_STATUS_READ, `SFP_OP_STATUS_WRITE,
      `SFP_OP_READ, `SFP_OP_PAGE_WRITE, `SFP_OP_SECTOR_WIPE, `SFP_OP_HALF_BLOCK_WIPE,
      `SFP_OP_BLOCK_WIPE, `SFP_OP_CHIP_WIPE_A, `SFP_OP_CHIP_WIPE_B, `SFP_OP_SECURE_ENTER,
      `SFP_OP_SECURE_EXIT, `SFP_OP_SEC_READ, `SFP_OP_SEC_WRITE, `SFP_OP_NOP: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction
  function automatic logic has_addr(input logic [7:0] op);
    has_addr = (op == `SFP_OP_READ) || (op == `SFP_OP_PAGE_WRITE) ||
      (op == `SFP_OP_SECTOR_WIPE) || (op == `SFP_OP_HALF_BLOCK_WIPE) ||
      (op == `SFP_OP_BLOCK_WIPE);
  endfunction
  function automatic logic is_output(input logic [7:0] op);
    is_output = (op == `SFP_OP_STATUS_READ) || (op == `SFP_OP_SEC_READ) ||
      (op == `SFP_OP_READ);
  endfunction

  // Frame sequencing and counters
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= sfp_pkg::DEV_IDLE;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
      op_r <= 8'h00;
      sh_r <= 8'h00;
    end else if (cs_fall) begin
      state_r <= sfp_pkg::DEV_CMD;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
    end else if (cs_rise) begin
      state_r <= sfp_pkg::DEV_IDLE;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
    end else if (sck_rise && state_r != sfp_pkg::DEV_IDLE && state_r != sfp_pkg::DEV_STANDBY) begin
      sh_r <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && byte_cnt_r != 4'hf) begin
        byte_cnt_r <= byte_cnt_r + 4'h1;
      end
      if (byte_done && state_r == sfp_pkg::DEV_CMD) begin
        op_r <= byte_in;
        if (!is_known(byte_in)) begin
          state_r <= sfp_pkg::DEV_STANDBY;
        end else if (has_addr(byte_in)) begin
          state_r <= sfp_pkg::DEV_ADDR;
        end else if (is_output(byte_in)) begin
          state_r <= sfp_pkg::DEV_DOUT;
        end else begin
          state_r <= sfp_pkg::DEV_DIN;
        end
      end else if (byte_done && state_r == sfp_pkg::DEV_ADDR &&
          byte_cnt_r == `SFP_ADDR_BYTES - 4'h1) begin
        state_r <= is_output(op_r) ? sfp_pkg::DEV_DOUT : sfp_pkg::DEV_DIN;
      end
    end
  end

  // Address capture, read address stepping, write data capture
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= 24'h000000;
      plen_r <= 9'h000;
      sr_new_r <= 8'h00;
      cr_new_r <= 8'h00;
    end else if (cs_fall) begin
      plen_r <= 9'h000;
    end else if (byte_done && state_r == sfp_pkg::DEV_ADDR) begin
      addr_r <= {addr_r[15:0], byte_in};
    end else if (byte_done && state_r == sfp_pkg::DEV_DIN) begin
      if (byte_cnt_r == `SFP_STATUS_WRITE_CMD_SR_BYTES - 4'h1) begin
        sr_new_r <= byte_in;
      end
      if (byte_cnt_r == `SFP_STATUS_WRITE_CMD_CR_BYTES - 4'h1) begin
        cr_new_r <= byte_in;
      end
      if (plen_r != 9'h100) begin
        plen_r <= plen_r + 9'h001;
      end
    end else if (load_pend_r && op_r == `SFP_OP_READ) begin
      addr_r <= addr_r + 24'h000001;
    end
  end

  // Page buffer, later drained by the array side
  always_ff @(posedge clk_in) begin
    if (byte_done && state_r == sfp_pkg::DEV_DIN) begin
      pbuf[addr_r[7:0] + plen_r[7:0]] <= byte_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_data_out <= 8'h00;
    end else begin
      buf_data_out <= pbuf[buf_idx_in];
    end
  end

  // Status, security and outgoing byte choice
  assign status_out = {srwd_r, qe_r, bp_r, wel_r, array_busy_in};
  assign sec_byte = {6'h00, cust_lock_r, factory_lock_in};
  assign rd_addr_out = addr_r[22:0];
  assign rd_otp_out = secure_r;
  assign secure_mode_out = secure_r;
  always_comb begin
    case (op_r)
      `SFP_OP_STATUS_READ: next_byte = status_out;
      `SFP_OP_SEC_READ: next_byte = sec_byte;
      default: next_byte = array_busy_in ? `SFP_IDLE_BYTE : rd_data_in;
    endcase
  end

  // Output shifter: load after each byte, drive on falling edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      load_pend_r <= 1'b0;
      tx_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      load_pend_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      load_pend_r <= byte_done && is_output(op_r) &&
        (state_r == sfp_pkg::DEV_DOUT || (state_r == sfp_pkg::DEV_ADDR &&
        byte_cnt_r == `SFP_ADDR_BYTES - 4'h1));
      if (byte_done && state_r == sfp_pkg::DEV_CMD && is_output(byte_in) &&
          !has_addr(byte_in)) begin
        load_pend_r <= 1'b1;
      end
      if (load_pend_r) begin
        tx_r <= next_byte;
      end else if (sck_fall && state_r == sfp_pkg::DEV_DOUT) begin
        so_r <= tx_r[7];
        so_oe_r <= 1'b1;
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end
  assign link.so_o = so_r;
  assign link.so_oe = so_oe_r;

  // Protection lookup on the 64K block of the captured address
  sfp_prot_dec u_prot (
    .level_in(bp_r),
    .protect_from_bottom_in(tb_r),
    .block_in(addr_r[`SFP_BLK_HI:`SFP_BLK_LO]),
    .protected_out(blk_prot)
  );
  assign pin_locked = srwd_r & ~link.wp_n & ~qe_r;

  // Command execution at deselect
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel_r <= 1'b0;
      bp_r <= 4'h0;
      srwd_r <= 1'b0;
      qe_r <= 1'b0;
      tb_r <= 1'b0;
      cust_lock_r <= 1'b0;
      secure_r <= 1'b0;
      op_start_out <= 1'b0;
      op_kind_out <= sfp_pkg::OP_PROG;
      op_addr_out <= 23'h000000;
      op_len_out <= 9'h000;
      op_otp_out <= 1'b0;
    end else begin
      op_start_out <= 1'b0;
      if (cs_rise && state_r == sfp_pkg::DEV_DIN && boundary) begin
        op_addr_out <= addr_r[22:0];
        op_len_out <= plen_r;
        op_otp_out <= secure_r;
        case (op_r)
          `SFP_OP_WRITE_UNLOCK: wel_r <= 1'b1;
          `SFP_OP_WRITE_LOCK: wel_r <= 1'b0;
          `SFP_OP_SECURE_ENTER: secure_r <= 1'b1;
          `SFP_OP_SECURE_EXIT: secure_r <= 1'b0;
          `SFP_OP_STATUS_WRITE: begin
            if (wel_r && !array_busy_in && !pin_locked &&
                byte_cnt_r >= `SFP_STATUS_WRITE_CMD_SR_BYTES) begin
              srwd_r <= sr_new_r[`SFP_SR_SRWD];
              qe_r <= sr_new_r[`SFP_SR_QE];
              bp_r <= sr_new_r[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
              if (byte_cnt_r >= `SFP_STATUS_WRITE_CMD_CR_BYTES) begin
                tb_r <= cr_new_r[`SFP_CR_TB];
              end
              wel_r <= 1'b0;
            end
          end
          `SFP_OP_SEC_WRITE: begin
            if (wel_r && !array_busy_in) begin
              cust_lock_r <= 1'b1;
              wel_r <= 1'b0;
            end
          end
          `SFP_OP_PAGE_WRITE: begin
            if (wel_r && !array_busy_in && byte_cnt_r >= `SFP_PROG_MIN_BYTES) begin
              wel_r <= 1'b0;
              op_kind_out <= sfp_pkg::OP_PROG;
              if (secure_r) begin
                // Half chosen by offset bit 9
                op_start_out <= addr_r[`SFP_OTP_HALF_BIT] ? !factory_lock_in :
                  !cust_lock_r;
              end else begin
                op_start_out <= !blk_prot;
              end
            end
          end
          `SFP_OP_SECTOR_WIPE, `SFP_OP_HALF_BLOCK_WIPE, `SFP_OP_BLOCK_WIPE: begin
            if (wel_r && !array_busy_in && byte_cnt_r == `SFP_ADDR_BYTES) begin
              wel_r <= 1'b0;
              op_start_out <= !blk_prot && !secure_r;
              op_kind_out <= (op_r == `SFP_OP_SECTOR_WIPE) ? sfp_pkg::OP_SECTOR :
                (op_r == `SFP_OP_HALF_BLOCK_WIPE) ? sfp_pkg::OP_HALF_BLOCK :
                sfp_pkg::OP_BLOCK;
            end
          end
          `SFP_OP_CHIP_WIPE_A, `SFP_OP_CHIP_WIPE_B: begin
            if (wel_r && !array_busy_in) begin
              wel_r <= 1'b0;
              op_start_out <= (bp_r == 4'h0) && !secure_r;
              op_kind_out <= sfp_pkg::OP_CHIP;
              op_addr_out <= 23'h000000; // Whole array, no stale address
            end
          end
          default: wel_r <= wel_r;
        endcase
      end
    end
  end
endmodule : sfp_dev

// [logic/sfp_host.sv]
`include "sfp_defs.svh"
module sfp_host #(
  parameter int DIV = 4,
  parameter bit CPOL = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  sfp_if.host link
);
  sfp_pkg::sfp_host_state_type state_r;
  logic [16:0] ctrl_r;
  logic [23:0] addr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [63:0] tx_r;
  logic [6:0] bits_r;
  logic [7:0] div_r;
  logic tick, sclk_r, cs_n_r, wr_acc, mapped, start;
  logic [6:0] total_bits;

  // Serial rate enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r <= 8'h00;
    end else begin
      div_r <= tick ? 8'h00 : div_r + 8'h01;
    end
  end
  assign tick = (div_r == 8'(DIV - 1));

  // APB decode, zero wait states
  assign pready = 1'b1;
  assign mapped = (paddr == `SFP_REG_CTRL) || (paddr == `SFP_REG_ADDR) ||
    (paddr == `SFP_REG_WDATA) || (paddr == `SFP_REG_RDATA) || (paddr == `SFP_REG_STAT);
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign start = wr_acc && paddr == `SFP_REG_CTRL && pwdata[15] &&
    state_r == sfp_pkg::HOST_IDLE;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `SFP_REG_CTRL: prdata <= {15'h0000, ctrl_r};
        `SFP_REG_ADDR: prdata <= {8'h00, addr_r};
        `SFP_REG_WDATA: prdata <= wdata_r;
        `SFP_REG_RDATA: prdata <= rdata_r;
        `SFP_REG_STAT: prdata <= {31'h00000000, state_r != sfp_pkg::HOST_IDLE};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= 17'h10000;
      addr_r <= 24'h000000;
      wdata_r <= 32'h00000000;
    end else if (wr_acc) begin
      case (paddr)
        `SFP_REG_CTRL: ctrl_r <= {pwdata[16], 1'b0, pwdata[14:0]};
        `SFP_REG_ADDR: addr_r <= pwdata[23:0];
        `SFP_REG_WDATA: wdata_r <= pwdata;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Frame length: opcode, optional address, bytes out and in
  assign total_bits = 7'h08 + (pwdata[8] ? 7'h18 : 7'h00) +
    {1'b0, pwdata[11:9], 3'h0} + {1'b0, pwdata[14:12], 3'h0};

  // Link sequencer: data changes on falls, device output taken on rises
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= sfp_pkg::HOST_IDLE;
      cs_n_r <= 1'b1;
      sclk_r <= CPOL;
      tx_r <= 64'h0;
      bits_r <= 7'h00;
      rdata_r <= 32'h00000000;
    end else if (start) begin
      state_r <= sfp_pkg::HOST_SETUP;
      cs_n_r <= 1'b0;
      bits_r <= total_bits;
      tx_r <= pwdata[8] ? {pwdata[7:0], addr_r, wdata_r} : {pwdata[7:0], wdata_r, 24'h000000};
    end else if (tick) begin
      unique case (state_r)
        sfp_pkg::HOST_IDLE: sclk_r <= CPOL;
        sfp_pkg::HOST_SETUP: begin
          sclk_r <= 1'b0;
          state_r <= sfp_pkg::HOST_LO;
        end
        sfp_pkg::HOST_LO: begin
          sclk_r <= 1'b1;
          rdata_r <= {rdata_r[30:0], link.so};
          state_r <= sfp_pkg::HOST_HI;
        end
        sfp_pkg::HOST_HI: begin
          if (bits_r == 7'h01) begin
            sclk_r <= CPOL;
            state_r <= sfp_pkg::HOST_END;
          end else begin
            sclk_r <= 1'b0;
            tx_r <= {tx_r[62:0], 1'b0};
            bits_r <= bits_r - 7'h01;
            state_r <= sfp_pkg::HOST_LO;
          end
        end
        sfp_pkg::HOST_END: begin
          cs_n_r <= 1'b1;
          state_r <= sfp_pkg::HOST_IDLE;
        end
      endcase
    end
  end
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.si = tx_r[63];
  assign link.wp_n = ctrl_r[16];
endmodule : sfp_host

// [sim/sfp_link_asserts.sv]
module sfp_link_asserts #(
  parameter bit CPOL = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_r;
  logic [15:0] rise_cnt_r;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Delayed serial clock for edge detection
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) sclk_r <= CPOL;
    else sclk_r <= sclk;
  end
  // Rises seen within the current frame
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rise_cnt_r <= 16'h0000;
    else if (cs_n) rise_cnt_r <= 16'h0000;
    else if (sclk && !sclk_r) rise_cnt_r <= rise_cnt_r + 16'h0001;
  end
  chk_oe_when_idle: assert property (cs_n [*4] |-> !so_oe)
    else $error("data out driven while deselected");
  chk_oe_drops_fast: assert property ($rose(cs_n) |-> ##[0:3] !so_oe)
    else $error("data out not released after deselect");
  chk_oe_first_low: assert property ($rose(so_oe) |-> !sclk)
    else $error("first output bit not launched on a falling edge");
  chk_out_on_fall: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sclk)
    else $error("output bit changed while clock high");
  chk_out_after_cmd: assert property ($rose(so_oe) |-> rise_cnt_r >= 16'h0008)
    else $error("output started before a full command byte");
  chk_in_stable_rise: assert property ($rose(sclk) && !cs_n |-> $stable(si))
    else $error("input bit changed at a rising clock");
  chk_idle_polarity: assert property (cs_n |-> sclk == CPOL)
    else $error("clock not at idle level while deselected");
  chk_sclk_half_len: assert property ($changed(sclk) |=> $stable(sclk) [*2])
    else $error("serial clock half period too short");
  chk_byte_deselect: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0)
    else $error("deselect off a byte boundary");
endmodule : sfp_link_asserts

// [sim/serial_flash_protect_and_framing_bench.sv]
`include "sfp_defs.svh"
module serial_flash_protect_and_framing_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic factory_lock_in, array_busy_in, rd_otp_out, op_start_out, op_otp_out, secure_mode_out;
  logic [7:0] rd_data_in, buf_idx_in, buf_data_out, status_out;
  logic [22:0] rd_addr_out, op_addr_out;
  logic [8:0] op_len_out;
  sfp_pkg::sfp_op_type op_kind_out;
  logic [71:0] op_q[$];
  logic [63:0] rd_q[$];
  int err_total = 0;
  int checked = 0;
  sfp_if lnk();
  sfp_host #(.DIV(4), .CPOL(1'b1)) u_sfp_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.host));
  sfp_dev u_sfp_dev (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(lnk.dev),
    .factory_lock_in(factory_lock_in), .array_busy_in(array_busy_in), .rd_data_in(rd_data_in),
    .rd_addr_out(rd_addr_out), .rd_otp_out(rd_otp_out), .op_start_out(op_start_out),
    .op_kind_out(op_kind_out), .op_addr_out(op_addr_out), .op_len_out(op_len_out),
    .op_otp_out(op_otp_out), .buf_idx_in(buf_idx_in), .buf_data_out(buf_data_out),
    .secure_mode_out(secure_mode_out), .status_out(status_out));
  sfp_link_asserts #(.CPOL(1'b1)) u_sfp_link_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cs_n(lnk.cs_n), .sclk(lnk.sclk), .si(lnk.si), .so_o(lnk.so_o), .so_oe(lnk.so_oe));
  // Array contents derived from the address
  assign rd_data_in = rd_addr_out[7:0] ^ 8'h3c;
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected guard of one 64K block
  function automatic logic prot(input logic [3:0] lv, input logic tb, input logic [6:0] b);
    int n;
    if (lv[3]) return 1'b1;
    if (lv == 4'h0) return 1'b0;
    n = 1 << (lv - 1);
    return tb ? (int'(b) < n) : (int'(b) >= 128 - n);
  endfunction : prot
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One serial frame, waits until the host is idle
  task automatic xfer(input logic [7:0] op, input logic a, input logic [2:0] nout,
                      input logic [2:0] nin, input logic [23:0] adr, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, `SFP_REG_ADDR, {8'h00, adr}, r, e);
    apb(1'b1, `SFP_REG_WDATA, wd, r, e);
    apb(1'b1, `SFP_REG_CTRL, {15'h0000, 1'b1, 1'b1, nin, nout, a, op}, r, e);
    r = 32'h00000001;
    while (r[0] !== 1'b0) apb(1'b0, `SFP_REG_STAT, 32'h00000000, r, e);
  endtask : xfer
  task automatic get(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    logic e;
    rd_q.push_back({m, v});
    apb(1'b0, `SFP_REG_RDATA, 32'h00000000, r, e);
  endtask : get
  task automatic stat(input logic [7:0] v);
    xfer(`SFP_OP_STATUS_READ, 1'b0, 3'h0, 3'h1, 24'h000000, 32'h00000000);
    get(32'h000000ff, {24'h000000, v});
  endtask : stat
  task automatic op(input logic [7:0] code, input logic a, input logic [2:0] nout,
                    input logic [23:0] adr, input logic [31:0] wd);
    xfer(code, a, nout, 3'h0, adr, wd);
  endtask : op
  task automatic push(input sfp_pkg::sfp_op_type k, input logic otp, input logic [22:0] adr,
                      input logic [8:0] len, input logic lm);
    op_q.push_back({3'h7, 1'b1, 23'h7fffff, lm ? 9'h1ff : 9'h000, k, otp, adr, len});
  endtask : push
  // Scoreboard on array operations and read data
  always @(posedge clk_in) begin
    if (op_start_out === 1'b1) begin
      if (op_q.size() == 0) check(36'h1, 36'h0);
      else begin
        check({op_kind_out, op_otp_out, op_addr_out, op_len_out} & op_q[0][71:36],
              op_q[0][35:0]);
        void'(op_q.pop_front());
      end
    end
    if (psel && penable && pready && !pwrite && paddr == `SFP_REG_RDATA) begin
      if (rd_q.size() == 0) check(36'h1, 36'h0);
      else begin
        check({4'h0, prdata & rd_q[0][63:32]}, {4'h0, rd_q[0][31:0]});
        void'(rd_q.pop_front());
      end
    end
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk_in);
    err_total++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [3:0] lv;
    logic [6:0] b;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {factory_lock_in, array_busy_in, buf_idx_in, rst_n_in} = '0;
    seed = 32'h00006c51;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    stat(8'h00);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h012345, 32'h000000a7);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    stat(8'h02);
    push(sfp_pkg::OP_PROG, 1'b0, 23'h012345, 9'h001, 1'b1);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h012345, 32'ha7000000);
    buf_idx_in <= 8'h45;
    repeat (2) @(posedge clk_in);
    check({28'h0, buf_data_out}, 36'ha7);
    stat(8'h00);
    xfer(`SFP_OP_READ, 1'b1, 3'h0, 3'h2, 24'h001230, 32'h0);
    get(32'h0000ffff, {16'h0000, 8'h30 ^ 8'h3c, 8'h31 ^ 8'h3c});
    $display("Test basic done");
    array_busy_in <= 1'b1;
    stat(8'h01);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h000100, 32'h00000011);
    xfer(`SFP_OP_READ, 1'b1, 3'h0, 3'h1, 24'h000100, 32'h0);
    get(32'h000000ff, 32'h000000ff);
    array_busy_in <= 1'b0;
    op(`SFP_OP_WRITE_LOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    stat(8'h00);
    xfer(8'h9f, 1'b0, 3'h0, 3'h1, 24'h0, 32'h0);
    get(32'h000000ff, 32'h000000ff);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({35'h0, e}, 36'h1);
    $display("Test busy and refusals done");
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      lv = (i == 0) ? 4'h0 : seed[3:0];
      b = seed[14:8];
      op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
      op(`SFP_OP_STATUS_WRITE, 1'b0, 3'h2, 24'h0, {2'b00, lv, 2'b00, 4'h0, seed[4], 3'h0, 16'h0});
      stat({2'b00, lv, 2'b00});
      op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
      if (!prot(lv, seed[4], b)) push(sfp_pkg::OP_BLOCK, 1'b0, {b, 16'h0}, 9'h0, 1'b0);
      op(`SFP_OP_BLOCK_WIPE, 1'b1, 3'h0, {1'b0, b, 16'h0000}, 32'h0);
      op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
      if (lv == 4'h0) push(sfp_pkg::OP_CHIP, 1'b0, 23'h0, 9'h0, 1'b0);
      op(i[0] ? `SFP_OP_CHIP_WIPE_A : `SFP_OP_CHIP_WIPE_B, 1'b0, 3'h0, 24'h0, 32'h0);
    end
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_STATUS_WRITE, 1'b0, 3'h2, 24'h0, 32'h0);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    push(sfp_pkg::OP_SECTOR, 1'b0, 23'h345000, 9'h0, 1'b0);
    op(`SFP_OP_SECTOR_WIPE, 1'b1, 3'h0, 24'h345000, 32'h0);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    push(sfp_pkg::OP_HALF_BLOCK, 1'b0, 23'h348000, 9'h0, 1'b0);
    op(`SFP_OP_HALF_BLOCK_WIPE, 1'b1, 3'h0, 24'h348000, 32'h0);
    $display("Test protection done");
    op(`SFP_OP_SECURE_ENTER, 1'b0, 3'h0, 24'h0, 32'h0);
    check({34'h0, secure_mode_out, rd_otp_out}, 36'h3);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    push(sfp_pkg::OP_PROG, 1'b1, 23'h000010, 9'h001, 1'b1);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h000010, 32'h0000005a);
    factory_lock_in <= 1'b1;
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h000210, 32'h0000005a);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_SECTOR_WIPE, 1'b1, 3'h0, 24'h000000, 32'h0);
    xfer(`SFP_OP_SEC_READ, 1'b0, 3'h0, 3'h1, 24'h0, 32'h0);
    get(32'h00000003, 32'h00000001);
    op(`SFP_OP_SECURE_EXIT, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_SEC_WRITE, 1'b0, 3'h0, 24'h0, 32'h0);
    xfer(`SFP_OP_SEC_READ, 1'b0, 3'h0, 3'h1, 24'h0, 32'h0);
    get(32'h00000003, 32'h00000003);
    op(`SFP_OP_SECURE_ENTER, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_WRITE_UNLOCK, 1'b0, 3'h0, 24'h0, 32'h0);
    op(`SFP_OP_PAGE_WRITE, 1'b1, 3'h1, 24'h000010, 32'h0000005a);
    op(`SFP_OP_SECURE_EXIT, 1'b0, 3'h0, 24'h0, 32'h0);
    check({34'h0, secure_mode_out, rd_otp_out}, 36'h0);
    $display("Test secure area done");
    repeat (20) @(posedge clk_in);
    check(36'(op_q.size()), 36'h0);
    check(36'(rd_q.size()), 36'h0);
    results();
  end
endmodule : serial_flash_protect_and_framing_bench
